// ===== dopi_chan.sv
/*
  Output stage of one channel: holds the commanded state, the error and
  warning flags, and drives the switch and the tristate enable.
  Assumes apply strobes are one-cycle pulses from the process image.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dopi_map.svh"

module dopi_chan
  import dopi_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        set_state,
  input  wire logic        set_ctrl,
  input  wire dopi_cmd_t   cmd,
  input  wire logic        fault_event,
  input  wire logic        warning_cond,
  input  wire logic        pwm_in,
  input  wire logic        ready_en,
  output dopi_flags_t      flags,
  output logic             drive_out,
  output logic             drive_hiz
);

  typedef struct packed {
    logic        cmd_on;
    logic        cmd_hiz;
    logic        cmd_pwm;
    dopi_flags_t flags;
    logic        drive;
    logic        hiz;
  } dopi_chan_state_t;

  dopi_chan_state_t state;
  dopi_chan_state_t next_state;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Commands, error handling and the pin drive are resolved here.
  always_comb begin
    next_state = state;
    if (set_state) begin
      next_state.cmd_on  = cmd.on;
      next_state.cmd_hiz = cmd.hiz;
    end
    if (set_ctrl) begin
      next_state.cmd_pwm = cmd.pwm;
    end
    // A fault in the same cycle as a clear request keeps the error set.
    if (fault_event) begin
      next_state.flags.err = 1'b1;
    end else if (set_ctrl && cmd.clr) begin
      next_state.flags.err = 1'b0;
    end
    next_state.flags.warn  = warning_cond;
    next_state.flags.ready = ready_en && !next_state.flags.err;
    // Tristate overrides output-on; an error forces the drivers off.
    next_state.flags.on  = next_state.cmd_on && !next_state.cmd_hiz
                           && !next_state.flags.err;
    next_state.flags.hiz = next_state.cmd_hiz || next_state.flags.err;
    next_state.flags.pwm = next_state.cmd_pwm && next_state.flags.on;
    next_state.hiz   = next_state.flags.hiz;
    next_state.drive = next_state.flags.on && (!next_state.cmd_pwm || pwm_in);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset leaves the channel off and the drivers released.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state     <= '0;
      state.hiz <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign flags     = state.flags;
  assign drive_out = state.drive;
  assign drive_hiz = state.hiz;

endmodule : dopi_chan

`default_nettype wire

// ===== dopi_image.sv
/*
  Cyclic process image of a two-channel switched digital output.
  Holds the control words taken from each exchange, builds the status
  words, the feedback byte and the extra info words, and runs the single
  timed switching order of distributed-clock mode.
  Assumes frame_strobe is a one-cycle pulse per process data exchange, and
  that dc_time is the local distributed-clock time in nanoseconds.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dopi_map.svh"

module dopi_image
  import dopi_pkg::*;
#(
  parameter int CHANNELS   = 2,
  parameter int WORD_W     = 16,
  parameter int TIME_W     = 64
)
(
  input  wire logic                                   clock,
  input  wire logic                                   rstn,
  input  wire logic                                   frame_strobe,
  input  wire logic                                   frame_ok,
  input  wire logic                                   link_operational,
  input  wire logic                                   dc_mode,
  input  wire logic                                   info_enable,
  input  wire dopi_info_cfg_t [CHANNELS-1:0]          info_cfg,
  input  wire logic [CHANNELS-1:0][WORD_W-1:0]        control_word_in,
  input  wire logic [7:0]                             activate_byte,
  input  wire logic [TIME_W-1:0]                      start_time,
  input  wire logic [TIME_W-1:0]                      dc_time,
  input  wire logic [CHANNELS-1:0]                    fault_event,
  input  wire logic [CHANNELS-1:0]                    warning_cond,
  input  wire logic [CHANNELS-1:0]                    pwm_in,
  input  wire logic [WORD_W-1:0]                      temperature,
  input  wire logic [CHANNELS-1:0][WORD_W-1:0]        load_current,
  output logic [CHANNELS-1:0][WORD_W-1:0]             channel_status_word,
  output logic [CHANNELS-1:0][WORD_W-1:0]             channel_control_word,
  output logic [7:0]                                  output_state_echo,
  output logic [CHANNELS-1:0][1:0][WORD_W-1:0]        extra_channel_words,
  output logic                                        working_counter_state,
  output logic [7:0]                                  esm_status,
  output logic [CHANNELS-1:0]                         drive_out,
  output logic [CHANNELS-1:0]                         drive_hiz
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Picks the source of one extra cyclic word.
  function automatic logic [WORD_W-1:0] info_value(
    input dopi_info_sel_t    sel,
    input logic [WORD_W-1:0] temp,
    input logic [WORD_W-1:0] current
  );
    logic [WORD_W-1:0] value;
    value = '0;
    unique case (sel)
      dopi_info_off:     value = '0;
      dopi_info_temp:    value = temp;
      dopi_info_current: value = current;
      default:           value = '0;
    endcase
    return value;
  endfunction : info_value

  // Packs the channel flags and the toggle into one status word.
  function automatic logic [WORD_W-1:0] status_word(
    input dopi_flags_t f,
    input logic        toggle
  );
    logic [WORD_W-1:0] word;
    word                  = '0;
    word[`DOPI_ST_READY]  = f.ready;
    word[`DOPI_ST_ON]     = f.on;
    word[`DOPI_ST_HIZ]    = f.hiz;
    word[`DOPI_ST_PWM]    = f.pwm;
    word[`DOPI_ST_WARN]   = f.warn;
    word[`DOPI_ST_ERR]    = f.err;
    word[`DOPI_ST_TOGGLE] = toggle;
    return word;
  endfunction : status_word

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [CHANNELS-1:0][WORD_W-1:0]      ctrl;
    logic [CHANNELS-1:0][WORD_W-1:0]      status;
    logic [CHANNELS-1:0][1:0][WORD_W-1:0] info;
    logic                                 toggle;
    logic [7:0]                           echo;
    logic                                 wc;
    logic [7:0]                           esm;
    logic [7:0]                           act_prev;
    dopi_order_t                          order;
    logic [TIME_W-1:0]                    pend_time;
    logic [CHANNELS-1:0]                  pend_on;
    logic [CHANNELS-1:0]                  pend_hiz;
    logic [TIME_W-1:0]                    order_time;
    logic [CHANNELS-1:0]                  order_on;
    logic [CHANNELS-1:0]                  order_hiz;
  } dopi_image_state_t;

  dopi_image_state_t state;
  dopi_image_state_t next_state;

  dopi_flags_t [CHANNELS-1:0] flags;
  dopi_cmd_t   [CHANNELS-1:0] cmd;
  logic        [CHANNELS-1:0] set_state;
  logic        [CHANNELS-1:0] set_ctrl;
  logic                       arm_now;
  logic                       fire_now;

  // ----------------------------------------------------------------------
  // Order scheduling
  // ----------------------------------------------------------------------
  // The order arms on a frame whose activation byte went from idle to arm,
  // and fires once the local clock has reached the stored start time.
  always_comb begin
    arm_now  = frame_strobe && dc_mode
               && activate_byte == `DOPI_ACT_ARM
               && state.act_prev == `DOPI_ACT_IDLE;
    fire_now = 1'b0;
    unique case (state.order)
      dopi_order_idle:  fire_now = 1'b0;
      dopi_order_armed: fire_now = dc_mode && (dc_time >= state.order_time);
    endcase
  end

  // ----------------------------------------------------------------------
  // Channel commands
  // ----------------------------------------------------------------------
  // Frame mode takes on and tristate straight from each frame; DC mode
  // takes them only from a fired order. PWM and error clear always come
  // from the frame, since they are not part of the timed order.
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      set_ctrl[i]  = frame_strobe;
      set_state[i] = 1'b0;
      cmd[i].pwm   = control_word_in[i][`DOPI_CT_PWM];
      cmd[i].clr   = control_word_in[i][`DOPI_CT_CLR];
      cmd[i].on    = control_word_in[i][`DOPI_CT_ON];
      cmd[i].hiz   = control_word_in[i][`DOPI_CT_HIZ];
      if (dc_mode) begin
        set_state[i] = fire_now;
        cmd[i].on    = state.order_on[i];
        cmd[i].hiz   = state.order_hiz[i];
      end else begin
        set_state[i] = frame_strobe;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state of the image
  // ----------------------------------------------------------------------
  // Status words are rebuilt every cycle, so they lag the channel flags by
  // one clock; that keeps every output on a flip-flop.
  always_comb begin
    next_state = state;
    for (int i = 0; i < CHANNELS; i++) begin
      next_state.status[i] = status_word(flags[i], state.toggle);
    end
    // Feedback byte is only meaningful in DC mode.
    next_state.echo = `DOPI_BYTE_RST;
    if (dc_mode) begin
      next_state.echo[`DOPI_FB_ON0]  = flags[0].on;
      next_state.echo[`DOPI_FB_HIZ0] = flags[0].hiz;
      next_state.echo[`DOPI_FB_ON1]  = flags[1].on;
      next_state.echo[`DOPI_FB_HIZ1] = flags[1].hiz;
    end
    next_state.esm = link_operational ? `DOPI_ESM_OP : `DOPI_ESM_PREOP;

    if (frame_strobe) begin
      next_state.toggle   = !state.toggle;
      next_state.act_prev = activate_byte;
      next_state.wc       = frame_ok ? `DOPI_WC_OK : `DOPI_WC_BAD;
      for (int i = 0; i < CHANNELS; i++) begin
        // Only implemented control bits are kept; the rest read zero.
        next_state.ctrl[i] = control_word_in[i] & `DOPI_CT_MASK;
        if (info_enable) begin
          next_state.info[i][0] = info_value(info_cfg[i].sel1, temperature,
                                             load_current[i]);
          next_state.info[i][1] = info_value(info_cfg[i].sel2, temperature,
                                             load_current[i]);
        end else begin
          next_state.info[i] = '0;
        end
      end
      // An idle activation byte carries the targets and start time.
      if (activate_byte == `DOPI_ACT_IDLE) begin
        next_state.pend_time = start_time;
        for (int i = 0; i < CHANNELS; i++) begin
          next_state.pend_on[i]  = control_word_in[i][`DOPI_CT_ON];
          next_state.pend_hiz[i] = control_word_in[i][`DOPI_CT_HIZ];
        end
      end
    end

    // A fired order frees the slot; a new arm in the same cycle overwrites.
    unique case (state.order)
      dopi_order_idle:  next_state.order = dopi_order_idle;
      dopi_order_armed: begin
        if (fire_now || !dc_mode) begin
          next_state.order = dopi_order_idle;
        end
      end
    endcase
    if (arm_now) begin
      next_state.order      = dopi_order_armed;
      next_state.order_time = state.pend_time;
      next_state.order_on   = state.pend_on;
      next_state.order_hiz  = state.pend_hiz;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // The bus state shows init until the first clock after reset.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state     <= '0;
      state.wc  <= `DOPI_WC_BAD;
      state.esm <= `DOPI_ESM_INIT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Channel output stages
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    dopi_chan u_chan (
      .clock        (clock),
      .rstn         (rstn),
      .set_state    (set_state[g]),
      .set_ctrl     (set_ctrl[g]),
      .cmd          (cmd[g]),
      .fault_event  (fault_event[g]),
      .warning_cond (warning_cond[g]),
      .pwm_in       (pwm_in[g]),
      .ready_en     (link_operational),
      .flags        (flags[g]),
      .drive_out    (drive_out[g]),
      .drive_hiz    (drive_hiz[g])
    );
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign channel_status_word   = state.status;
  assign channel_control_word  = state.ctrl;
  assign output_state_echo     = state.echo;
  assign extra_channel_words   = state.info;
  assign working_counter_state = state.wc;
  assign esm_status            = state.esm;

endmodule : dopi_image

`default_nettype wire

// ===== dopi_image_checker.sv
/*
  Concurrent checks on the ports of the dual output process image.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/100ps
`default_nettype none

module dopi_image_checker
  import dopi_pkg::*;
#(
  parameter int CHANNELS = 2,
  parameter int WORD_W   = 16
)
(
  input wire logic                              clock,
  input wire logic                              rstn,
  input wire logic                              frame_strobe,
  input wire logic                              frame_ok,
  input wire logic                              link_operational,
  input wire logic                              dc_mode,
  input wire logic [CHANNELS-1:0][WORD_W-1:0]   control_word_in,
  input wire logic [7:0]                        activate_byte,
  input wire logic [CHANNELS-1:0]               fault_event,
  input wire logic [CHANNELS-1:0][WORD_W-1:0]   channel_status_word,
  input wire logic [CHANNELS-1:0][WORD_W-1:0]   channel_control_word,
  input wire logic [7:0]                        output_state_echo,
  input wire logic                              working_counter_state,
  input wire logic [7:0]                        esm_status,
  input wire logic [CHANNELS-1:0]               drive_out,
  input wire logic [CHANNELS-1:0]               drive_hiz
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  // All checks share the one clock, so reset is written once here.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // The two steps of a timed order.
  sequence load_s;
    frame_strobe && dc_mode && activate_byte == 8'h00;
  endsequence
  sequence arm_s;
    frame_strobe && activate_byte == 8'h03;
  endsequence

  unused_bits_a: assert property (((channel_status_word[0] | channel_status_word[1])
    & 16'h7F30) == 16'h0000) else $error("unused status bit set");
  toggle_flip_a: assert property (frame_strobe |-> ##2
    channel_status_word[0][15] != $past(channel_status_word[0][15])) else $error("no toggle");
  ctrl_echo_a: assert property (frame_strobe |=> channel_control_word
    == ($past(control_word_in) & {2{16'h008E}})) else $error("control readback wrong");
  frame_on_a: assert property (frame_strobe && !dc_mode && control_word_in[0][3:1] == 3'b001
    && !fault_event[0] && !$past(fault_event[0]) && !channel_status_word[0][7]
    |=> drive_out[0]) else $error("output not switched on");
  hiz_wins_a: assert property (frame_strobe && !dc_mode && control_word_in[1][2]
    |=> drive_hiz[1] && !drive_out[1]) else $error("tristate lost priority");
  error_off_a: assert property (fault_event[0] |-> ##2 (channel_status_word[0][7]
    && !channel_status_word[0][0] && !drive_out[0] && drive_hiz[0])) else $error("error not held");
  wc_state_a: assert property (frame_strobe |=> working_counter_state
    == !$past(frame_ok)) else $error("working counter state wrong");
  esm_op_a: assert property (link_operational |=> esm_status == 8'h08)
    else $error("bus state not operational");
  echo_match_a: assert property (dc_mode && $past(dc_mode) |-> output_state_echo[3:0] ==
    {channel_status_word[1][2:1], channel_status_word[0][2:1]}) else $error("echo mismatch");
  dc_hold_a: assert property (load_s ##2 arm_s |=> $stable(drive_out))
    else $error("frame switched output in timed mode");
endmodule : dopi_image_checker

bind dopi_image dopi_image_checker #(.CHANNELS(CHANNELS), .WORD_W(WORD_W)) i_chk (
  .clock(clock), .rstn(rstn), .frame_strobe(frame_strobe), .frame_ok(frame_ok),
  .link_operational(link_operational), .dc_mode(dc_mode), .control_word_in(control_word_in),
  .activate_byte(activate_byte), .fault_event(fault_event), .drive_out(drive_out),
  .channel_status_word(channel_status_word), .channel_control_word(channel_control_word),
  .output_state_echo(output_state_echo), .working_counter_state(working_counter_state),
  .esm_status(esm_status), .drive_hiz(drive_hiz));

`default_nettype wire

// ===== dopi_image_test.sv
/*
  Self-checking bench for the dual output process image.
  Assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

module dopi_image_test
  import dopi_pkg::*;
;
  logic clock = 0, rstn = 0, link_operational = 1, dc_mode = 0, info_enable = 0;
  logic frame_strobe, frame_ok;
  logic [1:0][15:0] control_word_in, channel_status_word, channel_control_word, load_current;
  logic [1:0][1:0][15:0] extra_channel_words;
  logic [7:0] activate_byte, output_state_echo, esm_status;
  logic [63:0] start_time, dc_time = 64'h0123_4567_0000_0000, t_go;
  logic [1:0] fault_event = 0, warning_cond = 0, pwm_in = 0, drive_out, drive_hiz;
  logic [15:0] temperature = 16'h1234;
  logic working_counter_state, tg;
  dopi_info_cfg_t [1:0] info_cfg;
  int failures = 0, check_count = 0;

  dopi_master i_master (.clock(clock), .frame_strobe(frame_strobe),
    .control_word_in(control_word_in), .activate_byte(activate_byte),
    .start_time(start_time), .frame_ok(frame_ok));
  dopi_image i_dut (.clock(clock), .rstn(rstn), .frame_strobe(frame_strobe),
    .frame_ok(frame_ok), .link_operational(link_operational), .dc_mode(dc_mode),
    .info_enable(info_enable), .info_cfg(info_cfg), .control_word_in(control_word_in),
    .activate_byte(activate_byte), .start_time(start_time), .dc_time(dc_time),
    .fault_event(fault_event), .warning_cond(warning_cond), .pwm_in(pwm_in),
    .temperature(temperature), .load_current(load_current),
    .channel_status_word(channel_status_word), .channel_control_word(channel_control_word),
    .output_state_echo(output_state_echo), .extra_channel_words(extra_channel_words),
    .working_counter_state(working_counter_state), .esm_status(esm_status),
    .drive_out(drive_out), .drive_hiz(drive_hiz));

  // 10 MHz clock and a nanosecond time base that moves with it.
  always #50 clock = ~clock;
  always @(posedge clock) dc_time <= dc_time + 64'd100;

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask : tick

  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic t_frame;
    tg = channel_status_word[0][15];
    i_master.exchange(16'hFF73, 16'h0006, 8'h00, 64'd0, 1'b0);
    `CHK(channel_control_word, {16'h0006, 16'h0002})
    `CHK(drive_out, 2'b01)
    `CHK(drive_hiz, 2'b10)
    `CHK(working_counter_state, 1'b1)
    tick(1);
    `CHK(channel_status_word[0], {~tg, 15'h0003})
    `CHK(channel_status_word[1][2:0], 3'b101)
    i_master.exchange(16'h0000, 16'h0000, 8'h00, 64'd0, 1'b1);
    `CHK(working_counter_state, 1'b0)
    $display("test frame done");
  endtask : t_frame

  task automatic t_pwm;
    i_master.exchange(16'h000A, 16'h0000, 8'h00, 64'd0, 1'b1);
    tick(2);
    `CHK(channel_status_word[0][3], 1'b1)
    `CHK(drive_out[0], 1'b0)
    pwm_in = 2'b01;
    tick(2);
    `CHK(drive_out[0], 1'b1)
    pwm_in = 2'b00;
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_error;
    i_master.exchange(16'h0002, 16'h0000, 8'h00, 64'd0, 1'b1);
    fault_event = 2'b01;
    warning_cond = 2'b10;
    tick(1);
    fault_event = 2'b00;
    tick(1);
    `CHK(channel_status_word[0][7:0], 8'h84)
    `CHK(channel_status_word[1][6], 1'b1)
    `CHK(drive_out[0], 1'b0)
    warning_cond = 2'b00;
    i_master.exchange(16'h0082, 16'h0000, 8'h00, 64'd0, 1'b1);
    tick(2);
    `CHK(channel_status_word[0][7:0], 8'h03)
    `CHK(channel_status_word[1][6], 1'b0)
    `CHK(drive_out[0], 1'b1)
    $display("test error done");
  endtask : t_error

  task automatic t_info;
    info_enable = 1'b1;
    info_cfg = {{dopi_info_off, dopi_info_current}, {dopi_info_current, dopi_info_temp}};
    i_master.exchange(16'h0000, 16'h0000, 8'h00, 64'd0, 1'b1);
    `CHK(extra_channel_words, {16'h0000, 16'h5678, 16'h9ABC, 16'h1234})
    info_enable = 1'b0;
    i_master.exchange(16'h0000, 16'h0000, 8'h00, 64'd0, 1'b1);
    `CHK(extra_channel_words[0][0], 16'h0000)
    $display("test info done");
  endtask : t_info

  task automatic t_dc;
    int n;
    dc_mode = 1'b1;
    t_go = dc_time + 64'd2000;
    i_master.exchange(16'h0002, 16'h0004, 8'h00, t_go, 1'b1);
    i_master.exchange(16'h0000, 16'h0000, 8'h03, 64'd0, 1'b1);
    for (n = 0; n < 40 && drive_out[0] !== 1'b1; n++) tick(1);
    `CHK(dc_time - t_go, 64'd100)
    `CHK(drive_hiz, 2'b10)
    tick(1);
    `CHK(output_state_echo, 8'h09)
    i_master.exchange(16'h0000, 16'h0000, 8'h03, 64'd0, 1'b1);
    tick(5);
    `CHK(drive_out[0], 1'b1)
    dc_mode = 1'b0;
    i_master.exchange(16'h0000, 16'h0000, 8'h00, 64'd0, 1'b1);
    `CHK(drive_out[0], 1'b0)
    $display("test dc done");
  endtask : t_dc

  // Main sequence: two cycles of reset, then the scenarios in turn.
  initial begin
    info_cfg = '0;
    load_current = {16'h5678, 16'h9ABC};
    tick(2);
    rstn = 1'b1;
    tick(2);
    `CHK(esm_status, 8'h08)
    `CHK(channel_status_word[0][0], 1'b1)
    $display("test reset done");
    t_frame();
    t_pwm();
    t_error();
    t_info();
    t_dc();
    end_of_test();
  end

  // The scenarios need under a hundred cycles; 3000 means a hang.
  initial begin
    #300000;
    failures++;
    end_of_test();
  end
endmodule : dopi_image_test

`default_nettype wire

// ===== dopi_map.svh
/*
  Constants of the dual output process image: bit positions of the status
  and control words, the feedback byte layout, bus state codes and the
  activation byte codes.
  Assumes it is included by its bare name before the package and modules.
*/
`ifndef DOPI_MAP_SVH
`define DOPI_MAP_SVH

// ----------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------
`define DOPI_ST_READY   0
`define DOPI_ST_ON      1
`define DOPI_ST_HIZ     2
`define DOPI_ST_PWM     3
`define DOPI_ST_WARN    6
`define DOPI_ST_ERR     7
`define DOPI_ST_TOGGLE  15

// ----------------------------------------------------------------------
// Control word bit positions and the mask of implemented bits
// ----------------------------------------------------------------------
`define DOPI_CT_ON      1
`define DOPI_CT_HIZ     2
`define DOPI_CT_PWM     3
`define DOPI_CT_CLR     7
`define DOPI_CT_MASK    16'h008E

// ----------------------------------------------------------------------
// Feedback byte, bus state and activation codes, reset values
// ----------------------------------------------------------------------
`define DOPI_FB_ON0     0
`define DOPI_FB_HIZ0    1
`define DOPI_FB_ON1     2
`define DOPI_FB_HIZ1    3
`define DOPI_ESM_OP     8'h08
`define DOPI_ESM_PREOP  8'h02
`define DOPI_ESM_INIT   8'h01
`define DOPI_WC_OK      1'b0
`define DOPI_WC_BAD     1'b1
`define DOPI_ACT_IDLE   8'h00
`define DOPI_ACT_ARM    8'h03
`define DOPI_WORD_RST   16'h0000
`define DOPI_BYTE_RST   8'h00

`endif

// ===== dopi_master.sv
/*
  Behavioural bus master that exchanges one process data frame per call.
  Assumes the caller invokes exchange from a single process.
*/
`timescale 1ns/100ps
`default_nettype none

module dopi_master (
  input  wire logic        clock,
  output logic             frame_strobe,
  output logic [1:0][15:0] control_word_in,
  output logic [7:0]       activate_byte,
  output logic [63:0]      start_time,
  output logic             frame_ok
);
  // Idle values; no frame until the first call.
  initial begin
    frame_strobe = 1'b0;
    control_word_in = '0;
    activate_byte = 8'h00;
    start_time = '0;
    frame_ok = 1'b1;
  end

  // After each frame the data lines carry inverted junk, so a design that
  // samples them off the strobe shows up at once.
  task automatic exchange(input logic [15:0] w0, input logic [15:0] w1,
                          input logic [7:0] act, input logic [63:0] t, input logic ok);
    @(posedge clock);
    #10;
    frame_strobe = 1'b1;
    control_word_in = {w1, w0};
    activate_byte = act;
    start_time = t;
    frame_ok = ok;
    @(posedge clock);
    #10;
    frame_strobe = 1'b0;
    control_word_in = ~control_word_in;
    activate_byte = ~activate_byte;
    start_time = ~start_time;
  endtask : exchange
endmodule : dopi_master

`default_nettype wire

// ===== dopi_pkg.sv
/*
  Types shared by the dual output process image modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dopi_pkg;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Command that the output stage of one channel obeys.
  typedef struct packed {
    logic on;
    logic hiz;
    logic pwm;
    logic clr;
  } dopi_cmd_t;

  // Live flags of one channel, all from flip-flops in the output stage.
  typedef struct packed {
    logic ready;
    logic on;
    logic hiz;
    logic pwm;
    logic warn;
    logic err;
  } dopi_flags_t;

  // Source of one extra cyclic word.
  typedef enum logic [1:0] {
    dopi_info_off,
    dopi_info_temp,
    dopi_info_current
  } dopi_info_sel_t;

  // Selection of both extra words of a channel.
  typedef struct packed {
    dopi_info_sel_t sel2;
    dopi_info_sel_t sel1;
  } dopi_info_cfg_t;

  // State of the single timed switching order.
  typedef enum logic {
    dopi_order_idle,
    dopi_order_armed
  } dopi_order_t;

endpackage : dopi_pkg
